// [src/boot_loader_pkg.sv]
package boot_loader_pkg;
    localparam int CLK_HZ = 10000000;
    localparam logic [15:0] SYSTEM_CONFIGURATION_REG_BOOT = 16'h0E00;
    localparam logic [15:0] SERCTL_BOOT = 16'h8011;
    localparam logic [15:0] STK_UNDER_BOOT = 16'hFA40;
    localparam logic [15:0] STK_OVER_BOOT = 16'hFA0C;
    localparam logic [15:0] BANK_BASE_BOOT = 16'hFA00;
    localparam logic [15:0] STK_TOP_BOOT = 16'hFA40;
    localparam logic [23:0] LOAD_START = 24'h00FA40;
    localparam logic [23:0] LOAD_END = 24'h00FA5F;
    localparam logic [5:0] LOAD_COUNT = 6'h20;
    localparam logic [16:0] MEASURE_OFFSET = 17'h00024;
    localparam logic [16:0] MEASURE_DIVISOR = 17'h00048;
    localparam logic [23:0] FLASH_SEG0_LO = 24'h000000;
    localparam logic [23:0] FLASH_SEG0_HI = 24'h007FFF;
    localparam logic [23:0] FLASH_SEG1_LO = 24'h010000;
    localparam logic [23:0] FLASH_SEG1_HI = 24'h017FFF;
    localparam logic [3:0] BITS_PER_FRAME = 4'hA;
    localparam logic [3:0] BIT_SAMPLES = 4'hF;
    localparam logic [3:0] HALF_SAMPLES = 4'h7;
    typedef enum {ST_IDLE, ST_WAIT_START, ST_MEASURE, ST_SEND_ID, ST_LOAD, ST_RUN} boot_state_t;
endpackage

// [src/serial_link_if.sv]
`timescale 1ns/1ps
interface serial_link_if;
    logic [12:0] baudReload;
    logic txStart;
    logic [7:0] txData;
    logic txBusy;
    logic rxEnable;
    logic rxLine;
    logic rxValid;
    logic [7:0] rxData;
    logic txLine;
    modport ctrl(output baudReload, output txStart, output txData, output rxEnable,
        output rxLine, input txBusy, input rxValid, input rxData, input txLine);
    modport chan(input baudReload, input txStart, input txData, input rxEnable,
        input rxLine, output txBusy, output rxValid, output rxData, output txLine);
endinterface

// [src/async_serial_channel.sv]
`timescale 1ns/1ps
module async_serial_channel
    import boot_loader_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    serial_link_if.chan link
);
    // 16 ticks per bit, reload + 1 clocks per tick
    logic [12:0] tickCnt_reg;
    logic tick;
    logic [3:0] txSub_reg;
    logic [3:0] txBit_reg;
    logic [9:0] txShift_reg;
    logic txBusy_reg;
    logic [3:0] rxSub_reg;
    logic [3:0] rxBit_reg;
    logic [7:0] rxShift_reg;
    logic rxBusy_reg;
    logic rxValid_reg;
    logic [7:0] rxData_reg;

    assign tick = (tickCnt_reg == 13'h0000);
    assign link.txBusy = txBusy_reg;
    assign link.txLine = txShift_reg[0];
    assign link.rxValid = rxValid_reg;
    assign link.rxData = rxData_reg;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tickCnt_reg <= 13'h0000;
        end else if (tick) begin
            tickCnt_reg <= link.baudReload;
        end else begin
            tickCnt_reg <= tickCnt_reg - 13'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            txShift_reg <= 10'h3FF;
            txBusy_reg <= 1'b0;
            txSub_reg <= 4'h0;
            txBit_reg <= 4'h0;
        end else if (!txBusy_reg) begin
            if (link.txStart) begin
                txShift_reg <= {1'b1, link.txData, 1'b0};
                txBusy_reg <= 1'b1;
                txSub_reg <= 4'h0;
                txBit_reg <= 4'h0;
            end
        end else if (tick) begin
            txSub_reg <= txSub_reg + 4'h1;
            if (txSub_reg == BIT_SAMPLES) begin
                txShift_reg <= {1'b1, txShift_reg[9:1]};
                txBit_reg <= txBit_reg + 4'h1;
                if (txBit_reg == BITS_PER_FRAME - 4'h1) begin
                    txBusy_reg <= 1'b0;
                end
            end
        end
    end

    // receiver samples each bit at its middle tick
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rxBusy_reg <= 1'b0;
            rxSub_reg <= 4'h0;
            rxBit_reg <= 4'h0;
            rxShift_reg <= 8'h00;
            rxValid_reg <= 1'b0;
            rxData_reg <= 8'h00;
        end else begin
            rxValid_reg <= 1'b0;
            if (!link.rxEnable) begin
                rxBusy_reg <= 1'b0;
            end else if (!rxBusy_reg) begin
                if (!link.rxLine) begin
                    rxBusy_reg <= 1'b1;
                    rxSub_reg <= 4'h0;
                    rxBit_reg <= 4'h0;
                end
            end else if (tick) begin
                rxSub_reg <= rxSub_reg + 4'h1;
                if (rxSub_reg == HALF_SAMPLES) begin
                    rxBit_reg <= rxBit_reg + 4'h1;
                    if (rxBit_reg == 4'h0 && link.rxLine) begin
                        rxBusy_reg <= 1'b0;
                    end else if (rxBit_reg == BITS_PER_FRAME - 4'h1) begin
                        rxBusy_reg <= 1'b0;
                        rxValid_reg <= link.rxLine;
                        rxData_reg <= rxShift_reg;
                    end else if (rxBit_reg != 4'h0) begin
                        rxShift_reg <= {link.rxLine, rxShift_reg[7:1]};
                    end
                end
            end
        end
    end
endmodule

// [src/serial_boot_loader.sv]
// Function
// - boot strap low at hardware reset release selects serial boot mode
// - boot mode is entered whatever bus mode straps select
// - after init, watch receive line for a zero byte from the host
// - time zero byte, derive divisor, program channel, enable transmit pin
// - send one identification byte at the derived baud rate
// - watchdog held disabled throughout boot mode
// - system config 0E00h, channel control 8011h, underflow limit FA40h
// - bank base FA00h, stack top FA40h, overflow limit FA0Ch
// - transmit pin latch and direction bits both set to one
// - no instruction executes from internal flash during boot mode
// - receiver enabled only after id byte sent, then exactly 32 bytes
// - bytes stored in order to RAM FA40h through FA5Fh
// - after last byte, execution jumps to FA40h
// - boot mode persists after the jump with all its restrictions
// - external access strap ignored while boot mode is selected
// - code fetches of flash area go to boot ROM, data reads to flash
// - redirect range 0-7FFFh, or 10000h-17FFFh when flash in segment 1
// - without internal flash, data reads of flash area are undefined
// - boot mode ends only on reset; software reset always exits
// - baud reload is (timer count minus 36) divided by 72
`timescale 1ns/1ps
module serial_boot_loader
    import boot_loader_pkg::*;
#(
    parameter logic [7:0] ID_CODE = 8'h5A // arbitrary value
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic softResetReq,

    input wire logic bootSelectStrap,
    input wire logic externalAccessStrap,
    input wire logic flashInSegment1,
    input wire logic flashPresent,

    input wire logic serialReceiveLine,
    output logic serialTransmitLine,
    output logic serialTransmitOe,

    output logic serialBootMode,
    output logic watchdogDisable,
    output logic memMapUsesExtAccess,

    output logic [15:0] systemConfigurationReg,
    output logic [15:0] serialChannelControlReg,
    output logic [12:0] serialBaudReloadValue,

    output logic [15:0] stackUnderflowLimit,
    output logic [15:0] stackOverflowLimit,
    output logic [15:0] registerBankBase,
    output logic [15:0] stackTopPointer,
    output logic transmitPinLatchBit,
    output logic transmitPinDirectionBit,

    output logic ramWrite,
    output logic [23:0] ramAddr,
    output logic [7:0] ramData,
    output logic jumpValid,
    output logic [23:0] jumpAddr,
    output logic baudMeasureOverflow,

    input wire logic [23:0] fetchAddr,
    input wire logic fetchIsCode,
    output logic routeToBootRom,
    output logic flashDataUndefined
);
    serial_link_if link();
    boot_state_t state_reg;

    logic [1:0] rxSync_reg;
    logic [1:0] strapSync_reg;
    logic [1:0] extSync_reg;
    logic [1:0] settle_reg;

    logic resetSeen_reg;
    logic bootMode_reg;
    logic extAccess_reg;
    logic [15:0] sysConfig_reg;
    logic [15:0] chanControl_reg;
    logic [15:0] stkUnder_reg;
    logic [15:0] stkOver_reg;
    logic [15:0] bankBase_reg;
    logic [15:0] stkTop_reg;

    logic [16:0] baudMeasureTimer_reg;
    logic [12:0] reload_reg;
    logic txEn_reg;

    logic [5:0] loadCount_reg;
    logic [23:0] ramAddr_reg;
    logic [7:0] ramData_reg;
    logic ramWrite_reg;
    logic jumpValid_reg;
    logic overflow_reg;
    logic idSent_reg;

    logic inSeg0;
    logic inSeg1;
    logic inFlash;
    logic rxLine;
    logic [16:0] reloadWide;

    // two-flop synchronisers on the receive line and both strap pins
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rxSync_reg <= 2'b11;
            strapSync_reg <= 2'b11;
            extSync_reg <= 2'b00;
        end else begin
            rxSync_reg <= {rxSync_reg[0], serialReceiveLine};
            strapSync_reg <= {strapSync_reg[0], bootSelectStrap};
            extSync_reg <= {extSync_reg[0], externalAccessStrap};
        end
    end
    assign rxLine = rxSync_reg[1];

    // strap is read only once its pin value has reached the second sync stage
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            settle_reg <= 2'h0;
        end else begin
            settle_reg <= {settle_reg[0], 1'h1};
        end
    end

    // strap caught once, on the first synchronised sample after release
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            resetSeen_reg <= 1'b0;
            bootMode_reg <= 1'b0;
            extAccess_reg <= 1'b0;
        end else if (softResetReq) begin
            bootMode_reg <= 1'b0;
            extAccess_reg <= extSync_reg[1];
        end else if (!resetSeen_reg && settle_reg[1]) begin
            resetSeen_reg <= 1'b1;
            bootMode_reg <= !strapSync_reg[1];
            extAccess_reg <= extSync_reg[1];
        end
    end

    // boot values load on the same edge as the mode flag, so they never lag it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sysConfig_reg <= 16'h0000;
            chanControl_reg <= 16'h0000;
            stkUnder_reg <= 16'h0000;
            stkOver_reg <= 16'h0000;
            bankBase_reg <= 16'h0000;
            stkTop_reg <= 16'h0000;
        end else if (softResetReq) begin
            sysConfig_reg <= 16'h0000;
            chanControl_reg <= 16'h0000;
            stkUnder_reg <= 16'h0000;
            stkOver_reg <= 16'h0000;
            bankBase_reg <= 16'h0000;
            stkTop_reg <= 16'h0000;
        end else if (!resetSeen_reg && settle_reg[1] && !strapSync_reg[1]) begin
            sysConfig_reg <= SYSTEM_CONFIGURATION_REG_BOOT;
            chanControl_reg <= SERCTL_BOOT;
            stkUnder_reg <= STK_UNDER_BOOT;
            stkOver_reg <= STK_OVER_BOOT;
            bankBase_reg <= BANK_BASE_BOOT;
            stkTop_reg <= STK_TOP_BOOT;
        end
    end

    assign reloadWide = (baudMeasureTimer_reg - MEASURE_OFFSET) / MEASURE_DIVISOR;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            baudMeasureTimer_reg <= 17'h00000;
            reload_reg <= 13'h0000;
            txEn_reg <= 1'b0;
            overflow_reg <= 1'b0;
            idSent_reg <= 1'b0;
            loadCount_reg <= 6'h00;
            ramAddr_reg <= LOAD_START;
            ramData_reg <= 8'h00;
            ramWrite_reg <= 1'b0;
            jumpValid_reg <= 1'b0;
        end else begin
            ramWrite_reg <= 1'b0;
            jumpValid_reg <= 1'b0;
            if (softResetReq) begin
                state_reg <= ST_IDLE;
                txEn_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (bootMode_reg) begin
                            state_reg <= ST_WAIT_START;
                        end
                    end

                    ST_WAIT_START: begin
                        baudMeasureTimer_reg <= 17'h00000;
                        if (!rxLine) begin
                            state_reg <= ST_MEASURE;
                        end
                    end

                    ST_MEASURE: begin
                        // low period is start plus eight zero bits
                        if (rxLine) begin
                            if (baudMeasureTimer_reg < MEASURE_OFFSET) begin
                                reload_reg <= 13'h0000;
                            end else begin
                                reload_reg <= reloadWide[12:0];
                            end
                            txEn_reg <= 1'b1;
                            state_reg <= ST_SEND_ID;
                        end else if (baudMeasureTimer_reg[16]) begin
                            // too slow a host: channel cannot be set up
                            overflow_reg <= 1'b1;
                            state_reg <= ST_WAIT_START;
                        end else begin
                            baudMeasureTimer_reg <= baudMeasureTimer_reg + 17'h00001;
                        end
                    end

                    ST_SEND_ID: begin
                        if (link.txBusy) begin
                            idSent_reg <= 1'b1;
                        end else if (idSent_reg) begin
                            state_reg <= ST_LOAD;
                            loadCount_reg <= 6'h00;
                            ramAddr_reg <= LOAD_START;
                        end
                    end

                    ST_LOAD: begin
                        if (link.rxValid) begin
                            ramWrite_reg <= 1'b1;
                            ramData_reg <= link.rxData;
                            ramAddr_reg <= LOAD_START + {18'h00000, loadCount_reg};
                            loadCount_reg <= loadCount_reg + 6'h01;
                            if (loadCount_reg == LOAD_COUNT - 6'h01) begin
                                state_reg <= ST_RUN;
                                jumpValid_reg <= 1'b1;
                            end
                        end
                    end

                    ST_RUN: begin
                        state_reg <= ST_RUN;
                    end

                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign link.baudReload = reload_reg;
    assign link.txStart = (state_reg == ST_SEND_ID) && !idSent_reg && !link.txBusy;
    assign link.txData = ID_CODE;
    assign link.rxEnable = (state_reg == ST_LOAD) || (state_reg == ST_RUN);
    assign link.rxLine = rxLine;

    async_serial_channel channel (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .link(link)
    );

    assign serialTransmitLine = link.txLine;
    assign serialTransmitOe = txEn_reg;
    assign serialBootMode = bootMode_reg;
    assign watchdogDisable = bootMode_reg;
    assign memMapUsesExtAccess = extAccess_reg && !bootMode_reg;

    assign systemConfigurationReg = sysConfig_reg;
    assign serialChannelControlReg = chanControl_reg;
    assign stackUnderflowLimit = stkUnder_reg;
    assign stackOverflowLimit = stkOver_reg;
    assign registerBankBase = bankBase_reg;
    assign stackTopPointer = stkTop_reg;

    assign serialBaudReloadValue = reload_reg;
    assign transmitPinLatchBit = bootMode_reg;
    assign transmitPinDirectionBit = txEn_reg;

    assign ramWrite = ramWrite_reg;
    assign ramAddr = ramAddr_reg;
    assign ramData = ramData_reg;
    assign jumpValid = jumpValid_reg;
    assign jumpAddr = LOAD_START;

    assign baudMeasureOverflow = overflow_reg;

    // data reads of the flash area are never redirected, only code fetches
    assign inSeg0 = (fetchAddr >= FLASH_SEG0_LO) && (fetchAddr <= FLASH_SEG0_HI);
    assign inSeg1 = (fetchAddr >= FLASH_SEG1_LO) && (fetchAddr <= FLASH_SEG1_HI);
    assign inFlash = flashInSegment1 ? inSeg1 : inSeg0;
    assign routeToBootRom = bootMode_reg && inFlash && fetchIsCode;
    assign flashDataUndefined = bootMode_reg && inFlash && !fetchIsCode && !flashPresent;
endmodule

// [bench/boot_loader_chk.sv]
`timescale 1ns/1ps
module boot_loader_chk
    import boot_loader_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic softResetReq,
    input wire logic bootSelectStrap,
    input wire logic flashInSegment1,
    input wire logic flashPresent,
    input wire logic serialReceiveLine,
    input wire logic serialTransmitOe,
    input wire logic serialBootMode,
    input wire logic watchdogDisable,
    input wire logic memMapUsesExtAccess,
    input wire logic [15:0] systemConfigurationReg,
    input wire logic [15:0] serialChannelControlReg,
    input wire logic [15:0] stackUnderflowLimit,
    input wire logic [15:0] stackOverflowLimit,
    input wire logic [15:0] registerBankBase,
    input wire logic [15:0] stackTopPointer,
    input wire logic transmitPinLatchBit,
    input wire logic transmitPinDirectionBit,
    input wire logic ramWrite,
    input wire logic [23:0] ramAddr,
    input wire logic jumpValid,
    input wire logic [23:0] jumpAddr,
    input wire logic [23:0] fetchAddr,
    input wire logic fetchIsCode,
    input wire logic routeToBootRom,
    input wire logic flashDataUndefined
);
    logic [5:0] wrCount;
    logic inRange;
    assign inRange = flashInSegment1 ? (fetchAddr >= FLASH_SEG1_LO && fetchAddr <= FLASH_SEG1_HI)
        : (fetchAddr <= FLASH_SEG0_HI);
    // writes are never restarted without a hardware reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wrCount <= 6'h00;
        end else if (ramWrite) begin
            wrCount <= wrCount + 6'h01;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence lastWrite;
        ramWrite && wrCount == 6'h1F;
    endsequence
    AST_ENTRY: assert property ($rose(serialBootMode) |-> !$past(bootSelectStrap))
        else $error("boot mode without strap low");
    AST_OE: assert property ($rose(serialTransmitOe) |-> serialBootMode && $past(serialReceiveLine))
        else $error("tx enable early");
    AST_WDOG: assert property (watchdogDisable == serialBootMode)
        else $error("watchdog state wrong");
    AST_CFG: assert property (serialBootMode |-> systemConfigurationReg == SYSTEM_CONFIGURATION_REG_BOOT
        && serialChannelControlReg == SERCTL_BOOT && stackUnderflowLimit == STK_UNDER_BOOT)
        else $error("boot config values wrong");
    AST_STACK: assert property (serialBootMode |-> registerBankBase == BANK_BASE_BOOT
        && stackTopPointer == STK_TOP_BOOT && stackOverflowLimit == STK_OVER_BOOT)
        else $error("boot stack values wrong");
    AST_TXPIN: assert property (serialBootMode |-> transmitPinLatchBit
        && transmitPinDirectionBit == serialTransmitOe)
        else $error("tx pin bits wrong");
    AST_EXTIGN: assert property (serialBootMode |-> !memMapUsesExtAccess)
        else $error("ext strap used in boot mode");
    AST_ROUTE: assert property (routeToBootRom == (serialBootMode && fetchIsCode && inRange))
        else $error("fetch routing wrong");
    AST_UNDEF: assert property (serialBootMode && !flashPresent && !fetchIsCode && inRange
        |-> flashDataUndefined)
        else $error("undefined read not flagged");
    AST_RAMSEQ: assert property (ramWrite |-> wrCount < LOAD_COUNT
        && ramAddr == LOAD_START + {18'h00000, wrCount})
        else $error("ram write order wrong");
    AST_JUMP: assert property (jumpValid |-> lastWrite ##0 jumpAddr == LOAD_START)
        else $error("jump pulse wrong");
    AST_LAST: assert property (lastWrite |-> jumpValid)
        else $error("no jump after last byte");
    AST_STICKY: assert property ($fell(serialBootMode) |-> $past(softResetReq))
        else $error("boot mode left without reset");
endmodule

bind serial_boot_loader boot_loader_chk chk (
    .clk_sys, .rst_b, .softResetReq, .bootSelectStrap, .flashInSegment1, .flashPresent,
    .serialReceiveLine, .serialTransmitOe, .serialBootMode, .watchdogDisable,
    .memMapUsesExtAccess, .systemConfigurationReg, .serialChannelControlReg,
    .stackUnderflowLimit, .stackOverflowLimit, .registerBankBase, .stackTopPointer,
    .transmitPinLatchBit, .transmitPinDirectionBit, .ramWrite, .ramAddr, .jumpValid,
    .jumpAddr, .fetchAddr, .fetchIsCode, .routeToBootRom, .flashDataUndefined
);

// [bench/boot_host.sv]
`timescale 1ns/1ps
module boot_host (
    input wire logic clk_sys,
    input wire logic txLine,
    output logic rxLine
);
    initial rxLine = 1'h1;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic send_byte(input logic [7:0] b, input int bitClk, input int stopClk);
        rxLine = 1'h0;
        tick(bitClk);
        for (int i = 0; i < 8; i++) begin
            rxLine = b[i];
            tick(bitClk);
        end
        rxLine = 1'h1;
        tick(stopClk);
    endtask
    // half duplex: returns after the whole answer frame, or after 20000 clocks with no start bit
    task automatic get_byte(input int bitClk, output logic [7:0] b, output bit ok);
        int n;
        n = 0;
        ok = 1'b0;
        b = 8'h00;
        while (txLine !== 1'h0 && n < 20000) begin
            tick(1);
            n++;
        end
        if (n < 20000) begin
            tick(bitClk / 2);
            for (int i = 0; i < 8; i++) begin
                tick(bitClk);
                b[i] = txLine;
            end
            tick(bitClk);
            ok = (txLine === 1'h1);
            tick(bitClk);
        end
    endtask
endmodule

// [bench/serial_boot_loader_test.sv]
`timescale 1ns/1ps
module serial_boot_loader_test
    import boot_loader_pkg::*;
;
    localparam logic [7:0] ID = 8'hA3; // arbitrary value
    logic clk_sys, rst_b, softResetReq, bootSelectStrap, externalAccessStrap, fetchIsCode;
    logic flashInSegment1, flashPresent, serialReceiveLine, serialTransmitLine, serialBootMode;
    logic serialTransmitOe, watchdogDisable, memMapUsesExtAccess, transmitPinLatchBit;
    logic transmitPinDirectionBit, ramWrite, jumpValid, baudMeasureOverflow;
    logic routeToBootRom, flashDataUndefined;
    logic [15:0] systemConfigurationReg, serialChannelControlReg, stackUnderflowLimit;
    logic [15:0] stackOverflowLimit, registerBankBase, stackTopPointer;
    logic [12:0] serialBaudReloadValue;
    logic [23:0] ramAddr, jumpAddr, fetchAddr;
    logic [7:0] ramData;
    int nMismatch, testsRun, nWr;
    logic [23:0] wrAddr [32];
    logic [7:0] wrData [32];
    logic wrJump [32];
    serial_boot_loader #(.ID_CODE(ID)) dut (
        .clk_sys, .rst_b, .softResetReq, .bootSelectStrap, .externalAccessStrap,
        .flashInSegment1, .flashPresent, .serialReceiveLine, .serialTransmitLine,
        .serialTransmitOe, .serialBootMode, .watchdogDisable, .memMapUsesExtAccess,
        .systemConfigurationReg, .serialChannelControlReg, .serialBaudReloadValue,
        .stackUnderflowLimit, .stackOverflowLimit, .registerBankBase, .stackTopPointer,
        .transmitPinLatchBit, .transmitPinDirectionBit, .ramWrite, .ramAddr, .ramData,
        .jumpValid, .jumpAddr, .baudMeasureOverflow, .fetchAddr, .fetchIsCode,
        .routeToBootRom, .flashDataUndefined
    );
    boot_host host (.clk_sys, .txLine(serialTransmitLine), .rxLine(serialReceiveLine));
    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (ramWrite === 1'h1) begin
            if (nWr < 32) begin
                wrAddr[nWr] = ramAddr;
                wrData[nWr] = ramData;
                wrJump[nWr] = jumpValid;
            end
            nWr++;
        end
    end
    task automatic check(input bit ok, input string msg);
        testsRun++;
        if (!ok) begin
            nMismatch++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic hw_reset(input logic strap, input logic ext);
        rst_b = 1'h0;
        bootSelectStrap = strap;
        externalAccessStrap = ext;
        tick(12);
        rst_b = 1'h1;
        tick(8);
    endtask
    task automatic probe(input logic [23:0] a, input logic code, input logic exp);
        fetchAddr = a;
        fetchIsCode = code;
        tick(1);
        check(routeToBootRom === exp, "fetch routing");
    endtask
    task automatic t_normal;
        hw_reset(1'h1, 1'h1);
        check(serialBootMode === 1'h0 && watchdogDisable === 1'h0, "boot mode, strap high");
        check(memMapUsesExtAccess === 1'h1, "ext strap lost");
        probe(FLASH_SEG0_LO, 1'h1, 1'h0);
    endtask
    task automatic t_boot(input int r, input logic ext);
        logic [7:0] id;
        bit ok;
        hw_reset(1'h0, ext);
        nWr = 0;
        check(serialBootMode === 1'h1 && watchdogDisable === 1'h1, "no boot mode");
        check(memMapUsesExtAccess === 1'h0, "ext strap used");
        check(systemConfigurationReg === SYSTEM_CONFIGURATION_REG_BOOT, "config");
        check(serialChannelControlReg === SERCTL_BOOT, "channel control");
        check(stackUnderflowLimit === STK_UNDER_BOOT, "underflow limit");
        check(registerBankBase === BANK_BASE_BOOT, "bank base");
        check(stackTopPointer === STK_TOP_BOOT, "stack top");
        check(stackOverflowLimit === STK_OVER_BOOT, "overflow limit");
        // zero byte at half the answer bit time puts the count mid-step
        host.send_byte(8'h00, 8 * (r + 1), 0);
        host.get_byte(16 * (r + 1), id, ok);
        check(ok && id === ID, "id byte");
        check(serialBaudReloadValue === 13'(r), "baud reload");
        check(baudMeasureOverflow === 1'h0, "measure overflow");
        check(serialTransmitOe === 1'h1 && transmitPinDirectionBit === 1'h1, "tx pin");
        check(transmitPinLatchBit === 1'h1, "tx latch");
        check(nWr == 0, "ram written before id");
        for (int k = 0; k < 32; k++) begin
            host.send_byte(8'(k * 7 + 3), 16 * (r + 1), 16 * (r + 1));
        end
        tick(20);
        check(nWr == 32, "byte count");
        for (int k = 0; k < 32; k++) begin
            check(wrAddr[k] === LOAD_START + 24'(k) && wrData[k] === 8'(k * 7 + 3), "ram");
            check(wrJump[k] === (k == 31), "jump pulse");
        end
        check(jumpAddr === LOAD_START, "jump address");
        check(serialBootMode === 1'h1 && watchdogDisable === 1'h1, "mode after jump");
    endtask
    task automatic t_fetch;
        logic [23:0] lo;
        for (int s = 0; s < 2; s++) begin
            flashInSegment1 = s[0];
            lo = s[0] ? FLASH_SEG1_LO : FLASH_SEG0_LO;
            probe(lo, 1'h1, 1'h1);
            probe(lo + 24'h007FFF, 1'h1, 1'h1);
            probe(lo + 24'h008000, 1'h1, 1'h0);
            probe(lo ^ 24'h010000, 1'h1, 1'h0);
            probe(lo, 1'h0, 1'h0);
        end
        flashPresent = 1'h0;
        tick(1);
        check(flashDataUndefined === 1'h1, "undefined read");
        flashPresent = 1'h1;
        tick(1);
    endtask
    task automatic t_soft;
        softResetReq = 1'h1;
        tick(1);
        softResetReq = 1'h0;
        tick(2);
        check(serialBootMode === 1'h0 && systemConfigurationReg === 16'h0000, "soft reset");
        hw_reset(1'h1, 1'h0);
        check(serialBootMode === 1'h0 && watchdogDisable === 1'h0, "strap high reset");
    endtask
    task automatic finishTest;
        $display("comparisons %0d mismatches %0d", testsRun, nMismatch);
        if (nMismatch == 0 && testsRun > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        rst_b = 1'h0;
        softResetReq = 1'h0;
        bootSelectStrap = 1'h1;
        externalAccessStrap = 1'h0;
        flashInSegment1 = 1'h0;
        flashPresent = 1'h1;
        fetchAddr = 24'h000000;
        fetchIsCode = 1'h0;
        nMismatch = 0;
        testsRun = 0;
        nWr = 0;
        t_normal();
        t_boot(3, 1'h1);
        t_fetch();
        t_soft();
        t_boot(0, 1'h0);
        finishTest();
    end
    // about three times the expected run
    initial begin
        #9000000;
        nMismatch++;
        finishTest();
    end
endmodule
